// file: rtl/cwe_params.svh
// Constants for the card window enable and I/O control register bank.
// Assumes inclusion by bare name from the rtl folder.
`ifndef CWE_PARAMS_SVH
`define CWE_PARAMS_SVH

`define CWE_SOCK_BASE        12'h800
`define CWE_OFF_WIN_ENABLES  12'h806
`define CWE_OFF_IO_TIMING    12'h807
`define CWE_OFF_IO0_START_LO 12'h808
`define CWE_OFF_IO1_START_LO 12'h80C
`define CWE_IDX_CARD_B       8'h40
`define CWE_IDX_MASK         8'h3F
`define CWE_RST_BYTE         8'h00
`define CWE_EN_WRITABLE      8'hDF
`define CWE_BIT_IO1_OPEN     7
`define CWE_BIT_IO0_OPEN     6
`define CWE_BIT_RSVD         5
`define CWE_BIT_MEM_TOP      4
`define CWE_BIT_W1_WAIT      7
`define CWE_BIT_W1_SHORT     6
`define CWE_BIT_W1_AUTO      5
`define CWE_BIT_W1_WIDTH     4
`define CWE_BIT_W0_WAIT      3
`define CWE_BIT_W0_SHORT     2
`define CWE_BIT_W0_AUTO      1
`define CWE_BIT_W0_WIDTH     0

`endif

// file: rtl/cwe_pkg.sv
// Types shared by the card window register bank.
// Assumes nothing of its surroundings.
package cwe_pkg;
  typedef logic [7:0]  cwe_byte_t;
  typedef logic [11:0] cwe_addr_t;
  typedef enum logic [1:0] {
    CWE_WIDTH_8  = 2'h0,
    CWE_WIDTH_16 = 2'h1
  } cwe_width_t;
endpackage : cwe_pkg

// file: rtl/cwe_byte_store.sv
// Small byte memory holding the I/O window start-address low bytes.
// Assumes one write and one registered read per cycle, same clock.
`timescale 1ns/1ns
module cwe_byte_store #(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  // Write port
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_sel_i,
  input  wire cwe_pkg::cwe_byte_t       wr_data_i,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_sel_i,
  output cwe_pkg::cwe_byte_t            rd_data_o
);
  import cwe_pkg::*;
`include "cwe_params.svh"

  cwe_byte_t mem_q [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
          mem_q[g] <= `CWE_RST_BYTE;
        end else if (wr_en_i && wr_sel_i == g) begin
          mem_q[g] <= wr_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_data_o <= `CWE_RST_BYTE;
    end else begin
      rd_data_o <= mem_q[rd_sel_i];
    end
  end
endmodule : cwe_byte_store

// file: rtl/cwe_window_regs.sv
// Per-socket window enable, I/O timing/sizing and start-low registers.
// Assumes a single-cycle byte register port on the PCI clock, reached
// either by socket offset or by card index, and a card wide-I/O pin.
//
// Contract
// - A window whose enable bit is 0 is never claimed, whatever its addresses.
// - The window enable register reads 00h after reset.
// - Enable bit 7 opens I/O window 1 and bit 6 opens I/O window 0.
// - Enable bit 5 reads 0 and ignores writes.
// - Enable bits 4 to 0 open memory windows 4 to 0.
// - The extra-wait bit lengthens only 16-bit cycles of its I/O window.
// - The short-cycle bit shortens only 8-bit cycles of its I/O window.
// - With auto width set, width follows the card wide-I/O select pin.
// - Without auto width, the width bit picks 8 (0) or 16 (1) bits.
// - Each register answers at its socket offset and at its card index.
`timescale 1ns/1ns
module cwe_window_regs (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  // Register port
  input  wire logic               reg_rd_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_by_index_i,
  input  wire logic               card_b_i,
  input  wire cwe_pkg::cwe_addr_t reg_addr_i,
  input  wire cwe_pkg::cwe_byte_t reg_wdata_i,
  output cwe_pkg::cwe_byte_t      reg_rdata_o,
  output logic                    reg_ack_o,
  // Window hits from the address comparators
  input  wire logic [4:0]         mem_hit_i,
  input  wire logic [1:0]         io_hit_i,
  input  wire logic [1:0]         io_req_win_i,
  // Card pin
  input  wire logic               card_wide_io_select_i,
  // Window controls toward the cycle sequencer
  output logic [4:0]              mem_claim_o,
  output logic [1:0]              io_claim_o,
  output logic                    io_win1_open_o,
  output logic                    io_win0_open_o,
  output logic [1:0]              io_wide_o,
  output logic [1:0]              io_extra_wait_o,
  output logic [1:0]              io_short_cycle_o
);
  import cwe_pkg::*;
`include "cwe_params.svh"

  cwe_byte_t  enables_q;
  cwe_byte_t  timing_q;
  cwe_byte_t  start_rd;
  cwe_addr_t  off;
  logic       hit_en;
  logic       hit_tim;
  logic       hit_s0;
  logic       hit_s1;
  logic       rd_start_q;
  logic       rd_other_q;
  cwe_byte_t  rd_other_d;
  cwe_byte_t  rd_other_q_data;
  logic       wide_sync1_q;
  logic       wide_sync2_q;
  logic [1:0] auto_w;
  logic [1:0] fixed_w;
  logic [1:0] wide_now;

  // Both address forms fold onto the socket offset; the card B index is
  // the card A index plus 40h, so the select bit is dropped here.
  always_comb begin
    if (reg_by_index_i) begin
      off = `CWE_SOCK_BASE | {4'h0, reg_addr_i[7:0] & `CWE_IDX_MASK};
    end else begin
      off = reg_addr_i;
    end
  end

  // A card-B index with bit 6 (40h) clear or a card-A index with bit 6 set misses.
  logic idx_ok;
  assign idx_ok = !reg_by_index_i
                  || ((reg_addr_i[7:0] & `CWE_IDX_CARD_B) != 8'h00) == card_b_i;
  assign hit_en  = idx_ok && (off == `CWE_OFF_WIN_ENABLES);
  assign hit_tim = idx_ok && (off == `CWE_OFF_IO_TIMING);
  assign hit_s0  = idx_ok && (off == `CWE_OFF_IO0_START_LO);
  assign hit_s1  = idx_ok && (off == `CWE_OFF_IO1_START_LO);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      enables_q <= `CWE_RST_BYTE;
    end else if (reg_wr_i && hit_en) begin
      // Reserved bit 5 stays zero.
      enables_q <= reg_wdata_i & `CWE_EN_WRITABLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      timing_q <= `CWE_RST_BYTE;
    end else if (reg_wr_i && hit_tim) begin
      timing_q <= reg_wdata_i;
    end
  end

  // Start-address low bytes.
  cwe_byte_store #(
    .DEPTH (2)
  ) u_start (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (reg_wr_i && (hit_s0 || hit_s1)),
    .wr_sel_i  (hit_s1),
    .wr_data_i (reg_wdata_i),
    .rd_sel_i  (hit_s1),
    .rd_data_o (start_rd)
  );

  always_comb begin
    if (hit_en) begin
      rd_other_d = enables_q;
    end else if (hit_tim) begin
      rd_other_d = timing_q;
    end else begin
      rd_other_d = 8'h00;
    end
  end

  // Staged read data lags the request by one cycle to match the memory's
  // registered read port; the registered mux after it picks the source a cycle later.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_start_q      <= 1'b0;
      rd_other_q      <= 1'b0;
      rd_other_q_data <= `CWE_RST_BYTE;
    end else begin
      rd_start_q      <= reg_rd_i && (hit_s0 || hit_s1);
      rd_other_q      <= reg_rd_i;
      rd_other_q_data <= rd_other_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= `CWE_RST_BYTE;
      reg_ack_o   <= 1'b0;
    end else begin
      reg_ack_o   <= rd_other_q;
      reg_rdata_o <= rd_start_q ? start_rd : rd_other_q_data;
    end
  end

  // The card pin is asynchronous to the PCI clock.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wide_sync1_q <= 1'b0;
      wide_sync2_q <= 1'b0;
    end else begin
      wide_sync1_q <= card_wide_io_select_i;
      wide_sync2_q <= wide_sync1_q;
    end
  end

  assign auto_w  = {timing_q[`CWE_BIT_W1_AUTO], timing_q[`CWE_BIT_W0_AUTO]};
  assign fixed_w = {timing_q[`CWE_BIT_W1_WIDTH],
                    timing_q[`CWE_BIT_W0_WIDTH]};

  genvar w;
  generate
    for (w = 0; w < 2; w++) begin : g_io
      // Auto width wins; the fixed width bit is then ignored.
      assign wide_now[w] = auto_w[w] ? wide_sync2_q
                                     : fixed_w[w];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mem_claim_o      <= 5'h00;
      io_claim_o       <= 2'h0;
      io_win1_open_o   <= 1'b0;
      io_win0_open_o   <= 1'b0;
      io_wide_o        <= 2'h0;
      io_extra_wait_o  <= 2'h0;
      io_short_cycle_o <= 2'h0;
    end else begin
      // Hits into closed windows are dropped here.
      mem_claim_o    <= mem_hit_i & enables_q[`CWE_BIT_MEM_TOP:0];
      io_claim_o     <= io_hit_i & {enables_q[`CWE_BIT_IO1_OPEN],
                                    enables_q[`CWE_BIT_IO0_OPEN]};
      io_win1_open_o <= enables_q[`CWE_BIT_IO1_OPEN];
      io_win0_open_o <= enables_q[`CWE_BIT_IO0_OPEN];
      io_wide_o      <= wide_now;
      // Timing bits only reach the sequencer for matching widths.
      io_extra_wait_o  <= wide_now & {timing_q[`CWE_BIT_W1_WAIT],
                                      timing_q[`CWE_BIT_W0_WAIT]}
                          & io_req_win_i;
      io_short_cycle_o <= ~wide_now & {timing_q[`CWE_BIT_W1_SHORT],
                                       timing_q[`CWE_BIT_W0_SHORT]}
                          & io_req_win_i;
    end
  end
endmodule : cwe_window_regs

// file: verif/cwe_card_model.sv
// Card side model: drives the wide I/O select pin, promptly or slowly.
// Assumes the bench sets want_i and slow_i on the clock's rising edge.
`timescale 1ns/1ns
module cwe_card_model (
  input  wire logic clk_i,
  input  wire logic want_i,
  input  wire logic slow_i,
  output logic      sel_o
);
  logic [2:0] dly_q;
  // A slow card settles its select three cycles late; the block must wait.
  always_ff @(posedge clk_i) dly_q <= {dly_q[1:0], want_i};
  assign sel_o = slow_i ? dly_q[2] : want_i;
endmodule : cwe_card_model

// file: verif/cwe_window_monitor.sv
// Checker for the window register bank, bound to its top module.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/1ns
module cwe_window_monitor (
  input wire logic clk_i, reset_n_i, reg_rd_i, reg_wr_i, reg_ack_o,
  input wire logic io_win0_open_o,
  input wire cwe_pkg::cwe_addr_t reg_addr_i,
  input wire cwe_pkg::cwe_byte_t reg_rdata_o,
  input wire logic [4:0] mem_hit_i, mem_claim_o,
  input wire logic [1:0] io_hit_i, io_claim_o, io_req_win_i,
  input wire logic [1:0] io_extra_wait_o, io_short_cycle_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_ack; reg_rd_i |-> ##2 reg_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("read not acked");
  property p_only; reg_ack_o |-> $past(reg_rd_i, 2); endproperty
  a_only: assert property (p_only) else $error("stray ack");
  property p_rsvd;
    reg_ack_o && $past(reg_addr_i, 2) == 12'h806 |-> !reg_rdata_o[5];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("bit 5 set");
  property p_mem; (mem_claim_o & ~$past(mem_hit_i)) == 5'h00; endproperty
  a_mem: assert property (p_mem) else $error("mem claim no hit");
  property p_io; (io_claim_o & ~$past(io_hit_i)) == 2'h0; endproperty
  a_io: assert property (p_io) else $error("io claim no hit");
  property p_rst;
    $rose(reset_n_i) |-> io_claim_o == 2'h0 && mem_claim_o == 5'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("claim at reset");
  property p_wait;
    (io_extra_wait_o & ~$past(io_req_win_i)) == 2'h0;
  endproperty
  a_wait: assert property (p_wait) else $error("wait no req");
  property p_short;
    (io_short_cycle_o & ~$past(io_req_win_i)) == 2'h0;
  endproperty
  a_short: assert property (p_short) else $error("short no req");
  property p_open;
    $changed(io_win0_open_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2);
  endproperty
  a_open: assert property (p_open) else $error("open moved");
  c_ack: cover property (reg_ack_o);
  c_mem: cover property (mem_claim_o != 5'h00);
  c_wait: cover property (io_extra_wait_o != 2'h0);
endmodule : cwe_window_monitor
bind cwe_window_regs cwe_window_monitor mon (.*);

// file: verif/tb_top.sv
// Self-checking bench for the window register bank.
// Assumes the card model drives the wide select pin.
`timescale 1ns/1ns
module tb_top;
  import cwe_pkg::*;
  logic clk_i = 0, reset_n_i = 0, rd = 0, wr = 0, ix = 0, cb = 0;
  logic want = 0, slow = 0, pin, ack, w1, w0;
  logic [4:0] mh = 5'h00, mc;
  logic [1:0] ih = 2'h0, rq = 2'h0, ic, iw, ew, sc;
  cwe_addr_t ad = 12'h000;
  cwe_byte_t wd = 8'h00, rdat;
  int fails = 0, tests_run = 0;
  always #5 clk_i = ~clk_i;
  cwe_card_model card (.clk_i, .want_i(want), .slow_i(slow), .sel_o(pin));
  cwe_window_regs uut (.clk_i, .reset_n_i, .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_by_index_i(ix), .card_b_i(cb), .reg_addr_i(ad), .reg_wdata_i(wd),
    .reg_rdata_o(rdat), .reg_ack_o(ack), .mem_hit_i(mh), .io_hit_i(ih),
    .io_req_win_i(rq), .card_wide_io_select_i(pin), .mem_claim_o(mc),
    .io_claim_o(ic), .io_win1_open_o(w1), .io_win0_open_o(w0),
    .io_wide_o(iw), .io_extra_wait_o(ew), .io_short_cycle_o(sc));
  task automatic summarize;
    $display("counts: %0d checks, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(cwe_byte_t s, cwe_byte_t e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  // One request, held for exactly one taking edge.
  task automatic acc(logic w, logic i, cwe_addr_t a, cwe_byte_t d);
    rd <= !w;
    wr <= w;
    ix <= i;
    ad <= a;
    wd <= d;
    @(posedge clk_i);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask : acc
  task automatic rdc(logic i, cwe_addr_t a, cwe_byte_t e);
    int n;
    n = 0;
    acc(1'b0, i, a, 8'h00);
    // Look only at falling edges, where the registered answer has settled.
    do begin
      @(negedge clk_i);
      n++;
      if (n > 8) begin
        fails++;
        summarize();
      end
    end while (ack !== 1'b1);
    chk(rdat, e);
    @(posedge clk_i);
  endtask : rdc
  task automatic settle(int c);
    repeat (c) @(negedge clk_i);
  endtask : settle
  task automatic t_enables;
    rdc(1'b0, 12'h806, 8'h00);
    rdc(1'b0, 12'h808, 8'h00);
    acc(1'b1, 1'b0, 12'h806, 8'hFF);
    rdc(1'b0, 12'h806, 8'hDF);
    mh <= 5'h1F;
    ih <= 2'h3;
    settle(2);
    chk({1'b0, ic, mc}, 8'h7F);
    chk({6'h00, w1, w0}, 8'h03);
    @(posedge clk_i);
    acc(1'b1, 1'b0, 12'h806, 8'h85);
    settle(2);
    chk({1'b0, ic, mc}, 8'h45);
    @(posedge clk_i);
    acc(1'b1, 1'b0, 12'h806, 8'h00);
    settle(2);
    chk({1'b0, ic, mc}, 8'h00);
    @(posedge clk_i);
    $display("enables done");
  endtask : t_enables
  task automatic t_index;
    acc(1'b1, 1'b1, 12'h006, 8'h41);
    rdc(1'b0, 12'h806, 8'h41);
    cb <= 1'b1;
    acc(1'b1, 1'b1, 12'h006, 8'hFF);
    rdc(1'b1, 12'h046, 8'h41);
    acc(1'b1, 1'b1, 12'h048, 8'hA5);
    acc(1'b1, 1'b0, 12'h80C, 8'h5A);
    rdc(1'b0, 12'h808, 8'hA5);
    rdc(1'b1, 12'h04C, 8'h5A);
    rdc(1'b0, 12'h800, 8'h00);
    $display("index done");
  endtask : t_index
  task automatic t_size;
    acc(1'b1, 1'b0, 12'h807, 8'h01);
    settle(5);
    chk({6'h00, iw}, 8'h01);
    @(posedge clk_i);
    want <= 1'b1;
    slow <= 1'b1;
    acc(1'b1, 1'b0, 12'h807, 8'h22);
    settle(8);
    chk({6'h00, iw}, 8'h03);
    @(posedge clk_i);
    want <= 1'b0;
    acc(1'b1, 1'b0, 12'h807, 8'hDC);
    rq <= 2'h3;
    settle(8);
    chk({2'h0, ew, 2'h0, sc}, 8'h21);
    @(posedge clk_i);
    $display("sizing done");
  endtask : t_size
  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    t_enables();
    t_index();
    t_size();
    summarize();
  end
endmodule : tb_top
